//--- include/rvcb_map.vh
// Register offsets, field layout, masks and reset values of the voltage config bank
`ifndef RVCB_MAP_VH
`define RVCB_MAP_VH

// Register offsets (byte addresses on the 8-bit register port)
`define RVCB_CONV1_CONFIG          8'h2E
`define RVCB_CONV1_ACTIVE_VOLTAGE  8'h2F
`define RVCB_CONV1_SLEEP_VOLTAGE   8'h30
`define RVCB_CONV1_SCALING_VOLTAGE 8'h31
`define RVCB_CONV2_CONFIG          8'h32
`define RVCB_CONV2_ACTIVE_VOLTAGE  8'h33
`define RVCB_CONV2_SLEEP_VOLTAGE   8'h34
`define RVCB_CONV2_SCALING_VOLTAGE 8'h35
`define RVCB_CONV3_CONFIG          8'h36
`define RVCB_CONV4_CONFIG          8'h37
`define RVCB_CONV4_ACTIVE_VOLTAGE  8'h38
`define RVCB_CONV4_SLEEP_VOLTAGE   8'h39
`define RVCB_HOLE                  8'h3A
`define RVCB_LINREG1_ACTIVE_VOLTAGE 8'h3B
`define RVCB_LINREG1_SLEEP_VOLTAGE 8'h3C
`define RVCB_LINREG2_ACTIVE_VOLTAGE 8'h3D
`define RVCB_LINREG2_SLEEP_VOLTAGE 8'h3E
`define RVCB_LINREG3_ACTIVE_VOLTAGE 8'h3F
`define RVCB_LINREG3_SLEEP_VOLTAGE 8'h40
`define RVCB_LINREG4_ACTIVE_VOLTAGE 8'h41
`define RVCB_LINREG4_SLEEP_VOLTAGE 8'h42
`define RVCB_LINREG5_ACTIVE_VOLTAGE 8'h43
`define RVCB_LINREG5_SLEEP_VOLTAGE 8'h44
`define RVCB_FIRST                 8'h2E
`define RVCB_COUNT                 23

// Config field positions
`define RVCB_PHASE_BIT             6
`define RVCB_SLEW_HI               4
`define RVCB_SLEW_LO               3
`define RVCB_ILMIN_HI              2
`define RVCB_ILMIN_LO              0

// Writable bit masks; all other bits are reserved and read zero
`define RVCB_MASK_CFG_SLEW         8'h5F
`define RVCB_MASK_CFG_PLAIN        8'h47
`define RVCB_MASK_CODE6            8'h3F
`define RVCB_MASK_CODE5            8'h1F
`define RVCB_MASK_CODE4            8'h0F
`define RVCB_MASK_NONE             8'h00

// Reset values
`define RVCB_RST_CFG               8'h01
`define RVCB_RST_CONV4_CFG         8'h00
`define RVCB_RST_ZERO              8'h00

`endif

//--- rtl/rvcb_regbank.v
// Voltage and converter configuration register bank with output code selection
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Converter config bit 6 selects inverted phase
// - Converters 1/2 slew code in bits 4:3
// - Minimum coil current code in bits 2:0
// - Converter 1-3 config resets to 0x01
// - Converter 4 config resets to 0x00
// - Converter 1/2 six-bit active voltage codes
// - Converter 1/2 six-bit sleep codes reset zero
// - Converter 1/2 six-bit scaling codes reset zero
// - Active codes reset from boot configuration
// - Converter 4 four-bit active/sleep codes
// - Linear regs 1,2,4,5 five-bit active codes
// - Linear regs 1,2,4,5 sleep codes reset zero
// - Linear reg 3 four-bit active/sleep codes
// - Linear reg 3 sleep code resets zero
// - Sleep allow enters sleep; clearing wakes
// - Scaling pin polarity selectable per pin
//////////////////////////////////////////////////////////////////////////////
`include "rvcb_map.vh"

module rvcb_regbank (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_rst,
   // Register port from the serial bus engine
   input  wire [7:0] i_addr,
   input  wire       i_wr,
   input  wire [7:0] i_wdata,
   output reg  [7:0] o_rdata,
   // Boot-defined active codes, taken while reset is high
   input  wire [7:0] i_boot_conv1_active,
   input  wire [7:0] i_boot_conv2_active,
   input  wire [7:0] i_boot_conv4_active,
   input  wire [7:0] i_boot_linreg1_active,
   input  wire [7:0] i_boot_linreg2_active,
   input  wire [7:0] i_boot_linreg3_active,
   input  wire [7:0] i_boot_linreg4_active,
   input  wire [7:0] i_boot_linreg5_active,
   // Device state and scaling pins
   input  wire       i_sleep_allow,
   input  wire       i_scaling_pin1,
   input  wire       i_scaling_pin1_polarity,
   input  wire       i_scaling_pin2,
   input  wire       i_scaling_pin2_polarity,
   output reg        o_sleep_state,
   output reg        o_wake_pulse,
   // Converter configuration fields
   output wire       o_conv1_phase_invert,
   output wire       o_conv2_phase_invert,
   output wire       o_conv3_phase_invert,
   output wire       o_conv4_phase_invert,
   output wire [1:0] o_conv1_scaling_slew,
   output wire [1:0] o_conv2_scaling_slew,
   output wire [2:0] o_conv1_min_coil_current,
   output wire [2:0] o_conv2_min_coil_current,
   output wire [2:0] o_conv3_min_coil_current,
   output wire [2:0] o_conv4_min_coil_current,
   // Codes presented to the regulators
   output reg  [5:0] o_conv1_code,
   output reg  [5:0] o_conv2_code,
   output reg  [3:0] o_conv4_code,
   output reg  [4:0] o_linreg1_code,
   output reg  [4:0] o_linreg2_code,
   output reg  [3:0] o_linreg3_code,
   output reg  [4:0] o_linreg4_code,
   output reg  [4:0] o_linreg5_code
);

   localparam ST_ACTIVE = 1'b0;
   localparam ST_SLEEP  = 1'b1;

   //////////////////////////////////////////////////////////////////////////
   // Writable bits per offset; reserved bits never store
   function [7:0] wmask;
      input [7:0] a;
      begin
         case (a)
            `RVCB_CONV1_CONFIG, `RVCB_CONV2_CONFIG:       wmask = `RVCB_MASK_CFG_SLEW;
            `RVCB_CONV3_CONFIG, `RVCB_CONV4_CONFIG:       wmask = `RVCB_MASK_CFG_PLAIN;
            `RVCB_CONV1_ACTIVE_VOLTAGE, `RVCB_CONV1_SLEEP_VOLTAGE,
            `RVCB_CONV1_SCALING_VOLTAGE, `RVCB_CONV2_ACTIVE_VOLTAGE,
            `RVCB_CONV2_SLEEP_VOLTAGE, `RVCB_CONV2_SCALING_VOLTAGE:
               wmask = `RVCB_MASK_CODE6;
            `RVCB_CONV4_ACTIVE_VOLTAGE, `RVCB_CONV4_SLEEP_VOLTAGE,
            `RVCB_LINREG3_ACTIVE_VOLTAGE, `RVCB_LINREG3_SLEEP_VOLTAGE:
               wmask = `RVCB_MASK_CODE4;
            `RVCB_LINREG1_ACTIVE_VOLTAGE, `RVCB_LINREG1_SLEEP_VOLTAGE,
            `RVCB_LINREG2_ACTIVE_VOLTAGE, `RVCB_LINREG2_SLEEP_VOLTAGE,
            `RVCB_LINREG4_ACTIVE_VOLTAGE, `RVCB_LINREG4_SLEEP_VOLTAGE,
            `RVCB_LINREG5_ACTIVE_VOLTAGE, `RVCB_LINREG5_SLEEP_VOLTAGE:
               wmask = `RVCB_MASK_CODE5;
            default: wmask = `RVCB_MASK_NONE;
         endcase
      end
   endfunction

   // Fixed reset word for registers without a boot value
   function [7:0] rst_val;
      input [7:0] a;
      begin
         case (a)
            `RVCB_CONV1_CONFIG, `RVCB_CONV2_CONFIG,
            `RVCB_CONV3_CONFIG: rst_val = `RVCB_RST_CFG;
            `RVCB_CONV4_CONFIG: rst_val = `RVCB_RST_CONV4_CFG;
            default:            rst_val = `RVCB_RST_ZERO;
         endcase
      end
   endfunction

   // Offsets whose reset word comes from boot
   function is_boot;
      input [7:0] a;
      begin
         case (a)
            `RVCB_CONV1_ACTIVE_VOLTAGE, `RVCB_CONV2_ACTIVE_VOLTAGE,
            `RVCB_CONV4_ACTIVE_VOLTAGE, `RVCB_LINREG1_ACTIVE_VOLTAGE,
            `RVCB_LINREG2_ACTIVE_VOLTAGE, `RVCB_LINREG3_ACTIVE_VOLTAGE,
            `RVCB_LINREG4_ACTIVE_VOLTAGE, `RVCB_LINREG5_ACTIVE_VOLTAGE:
               is_boot = 1'b1;
            default: is_boot = 1'b0;
         endcase
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Boot words laid out by bank index, offset 0x2E at the low byte
   wire [8*`RVCB_COUNT-1:0] boot_flat;
   assign boot_flat = {8'h00, i_boot_linreg5_active, 8'h00, i_boot_linreg4_active,
                       8'h00, i_boot_linreg3_active, 8'h00, i_boot_linreg2_active,
                       8'h00, i_boot_linreg1_active, 8'h00, 8'h00,
                       i_boot_conv4_active, 8'h00, 8'h00, 8'h00, 8'h00,
                       i_boot_conv2_active, 8'h00, 8'h00, 8'h00,
                       i_boot_conv1_active, 8'h00};

   wire [7:0] bank_w [0:`RVCB_COUNT-1];

   //////////////////////////////////////////////////////////////////////////
   // One storage byte per offset; synchronous reset may sample boot ports
   genvar g;
   generate
      for (g = 0; g < `RVCB_COUNT; g = g + 1) begin : g_reg
         localparam [7:0] ADDR = `RVCB_FIRST + g;
         reg [7:0] val_q;
         always @(posedge i_clk) begin
            if (i_rst) begin
               if (is_boot(ADDR))
                  val_q <= boot_flat[8*g +: 8] & wmask(ADDR);
               else
                  val_q <= rst_val(ADDR);
            end else if (i_wr && (i_addr == ADDR)) begin
               val_q <= i_wdata & wmask(ADDR);
            end
         end
         assign bank_w[g] = val_q;
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // Registered read, one cycle after the address; unmapped reads zero
   wire [7:0] roff;
   assign roff = i_addr - `RVCB_FIRST;

   always @(posedge i_clk) begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if ((i_addr >= `RVCB_FIRST) && (roff < `RVCB_COUNT))
         o_rdata <= bank_w[roff[4:0]];
      else
         o_rdata <= 8'h00;
   end

   //////////////////////////////////////////////////////////////////////////
   // Configuration fields straight from storage flops
   assign o_conv1_phase_invert     = bank_w[0][`RVCB_PHASE_BIT];
   assign o_conv2_phase_invert     = bank_w[4][`RVCB_PHASE_BIT];
   assign o_conv3_phase_invert     = bank_w[8][`RVCB_PHASE_BIT];
   assign o_conv4_phase_invert     = bank_w[9][`RVCB_PHASE_BIT];
   assign o_conv1_scaling_slew     = bank_w[0][`RVCB_SLEW_HI:`RVCB_SLEW_LO];
   assign o_conv2_scaling_slew     = bank_w[4][`RVCB_SLEW_HI:`RVCB_SLEW_LO];
   assign o_conv1_min_coil_current = bank_w[0][`RVCB_ILMIN_HI:`RVCB_ILMIN_LO];
   assign o_conv2_min_coil_current = bank_w[4][`RVCB_ILMIN_HI:`RVCB_ILMIN_LO];
   assign o_conv3_min_coil_current = bank_w[8][`RVCB_ILMIN_HI:`RVCB_ILMIN_LO];
   assign o_conv4_min_coil_current = bank_w[9][`RVCB_ILMIN_HI:`RVCB_ILMIN_LO];

   //////////////////////////////////////////////////////////////////////////
   // Device state: sleep while allowed, wake pulse on leaving sleep
   reg state_d;
   always @* begin
      state_d = o_sleep_state;
      case (o_sleep_state)
         ST_ACTIVE: if (i_sleep_allow) state_d = ST_SLEEP;
         ST_SLEEP:  if (!i_sleep_allow) state_d = ST_ACTIVE;
         default:   state_d = ST_ACTIVE;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_sleep_state <= ST_ACTIVE;
         o_wake_pulse  <= 1'b0;
      end else begin
         o_sleep_state <= state_d;
         o_wake_pulse  <= (o_sleep_state == ST_SLEEP) && (state_d == ST_ACTIVE);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Scaling pins: asserted when the level matches its polarity bit
   wire scale1;
   wire scale2;
   assign scale1 = (i_scaling_pin1 == i_scaling_pin1_polarity);
   assign scale2 = (i_scaling_pin2 == i_scaling_pin2_polarity);

   // Code selection; scaling outranks sleep so a pin can override a nap
   wire slp;
   assign slp = (o_sleep_state == ST_SLEEP);

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_conv1_code   <= 6'h00;
         o_conv2_code   <= 6'h00;
         o_conv4_code   <= 4'h0;
         o_linreg1_code <= 5'h00;
         o_linreg2_code <= 5'h00;
         o_linreg3_code <= 4'h0;
         o_linreg4_code <= 5'h00;
         o_linreg5_code <= 5'h00;
      end else begin
         o_conv1_code   <= scale1 ? bank_w[3][5:0] :
                           (slp ? bank_w[2][5:0] : bank_w[1][5:0]);
         o_conv2_code   <= scale2 ? bank_w[7][5:0] :
                           (slp ? bank_w[6][5:0] : bank_w[5][5:0]);
         o_conv4_code   <= slp ? bank_w[11][3:0] : bank_w[10][3:0];
         o_linreg1_code <= slp ? bank_w[14][4:0] : bank_w[13][4:0];
         o_linreg2_code <= slp ? bank_w[16][4:0] : bank_w[15][4:0];
         o_linreg3_code <= slp ? bank_w[18][3:0] : bank_w[17][3:0];
         o_linreg4_code <= slp ? bank_w[20][4:0] : bank_w[19][4:0];
         o_linreg5_code <= slp ? bank_w[22][4:0] : bank_w[21][4:0];
      end
   end

endmodule // rvcb_regbank

//--- test/rvcb_checker.sv
// Assertions on the register port, sleep control and code outputs of the bank
`timescale 1ns/1ps
module rvcb_checker (
   input wire       i_clk,
   input wire       i_rst,
   input wire [7:0] i_addr,
   input wire       i_wr,
   input wire [7:0] i_wdata,
   input wire       i_sleep_allow,
   input wire [7:0] o_rdata,
   input wire       o_sleep_state,
   input wire       o_wake_pulse,
   input wire       o_conv1_phase_invert,
   input wire [1:0] o_conv1_scaling_slew,
   input wire [2:0] o_conv1_min_coil_current,
   input wire [3:0] o_conv4_code
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Write steps and the one-cycle wake event
   sequence s_cfg1_wr; i_wr && i_addr == 8'h2E; endsequence
   sequence s_wake; o_wake_pulse ##1 !o_wake_pulse; endsequence
   hole_reads_zero_a: assert property (i_addr == 8'h3A |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   phase_write_a: assert property (s_cfg1_wr |=> o_conv1_phase_invert == $past(i_wdata[6]))
      else $error("phase bit not taken");
   slew_write_a: assert property (s_cfg1_wr |=> o_conv1_scaling_slew == $past(i_wdata[4:3]))
      else $error("slew field not taken");
   coil_write_a: assert property (s_cfg1_wr |=> o_conv1_min_coil_current == $past(i_wdata[2:0]))
      else $error("coil current field not taken");
   // Readback two edges after the write, reserved bits cleared
   cfg4_readback_a: assert property (i_wr && i_addr == 8'h37 ##1 i_addr == 8'h37 |=>
      o_rdata == ($past(i_wdata, 2) & 8'h47)) else $error("config readback wrong");
   sleep_enter_a: assert property (i_sleep_allow |=> o_sleep_state)
      else $error("sleep not entered");
   wake_event_a: assert property (o_sleep_state && !i_sleep_allow |=> !o_sleep_state ##0 s_wake)
      else $error("wake transition wrong");
   no_stray_wake_a: assert property (!o_sleep_state |=> !o_wake_pulse)
      else $error("wake pulse without sleep");
   active_code_a: assert property (i_wr && i_addr == 8'h38 ##1 !o_sleep_state |=>
      o_conv4_code == $past(i_wdata[3:0], 2)) else $error("active code not presented");
endmodule // rvcb_checker

//--- test/rvcb_host.sv
// Host model issuing byte-wide register writes and reads
`timescale 1ns/1ps
module rvcb_host (
   input  wire       i_clk,
   input  wire [7:0] i_rdata,
   output reg  [7:0] o_addr,
   output reg        o_wr,
   output reg  [7:0] o_wdata
);
   // Idle port at time zero
   initial begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end
   // Data inverted after the strobe so stale data never looks valid
   task wr(input [7:0] a, input [7:0] d);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_clk);
      #1 o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   // Address taken on the next edge, answer registered on that edge
   task rd(input [7:0] a, output [7:0] d);
      o_addr = a;
      @(posedge i_clk);
      #1 d = i_rdata;
   endtask
endmodule // rvcb_host

//--- test/test_regulator_voltage_config_bank.sv
// Self-checking bench for the voltage configuration register bank
`timescale 1ns/1ps
module test_regulator_voltage_config_bank;
   logic       i_clk, i_rst, i_wr, i_sleep_allow, i_scaling_pin1, i_scaling_pin1_polarity;
   logic       i_scaling_pin2, i_scaling_pin2_polarity, o_sleep_state, o_wake_pulse;
   logic       o_conv1_phase_invert, o_conv2_phase_invert, o_conv3_phase_invert;
   logic       o_conv4_phase_invert;
   logic [7:0] i_addr, i_wdata, o_rdata, boot, v, a;
   logic [1:0] o_conv1_scaling_slew, o_conv2_scaling_slew;
   logic [2:0] o_conv1_min_coil_current, o_conv2_min_coil_current;
   logic [2:0] o_conv3_min_coil_current, o_conv4_min_coil_current;
   logic [5:0] o_conv1_code, o_conv2_code;
   logic [4:0] o_linreg1_code, o_linreg2_code, o_linreg4_code, o_linreg5_code;
   logic [3:0] o_conv4_code, o_linreg3_code;
   logic [7:0] pat [2] = '{8'hEF, 8'h10};
   logic [15:0] setup [10] = '{16'h2F11, 16'h3022, 16'h3133, 16'h352A, 16'h3805,
                               16'h3909, 16'h3F03, 16'h400C, 16'h2E5A, 16'h3746};
   int         n_mismatch = 0, tests_run = 0, cyc = 0;
   wire [7:0]  i_boot_conv1_active = boot, i_boot_conv2_active = boot,
               i_boot_conv4_active = boot, i_boot_linreg1_active = boot,
               i_boot_linreg2_active = boot, i_boot_linreg3_active = boot,
               i_boot_linreg4_active = boot, i_boot_linreg5_active = boot;
   rvcb_regbank i_dut (.*);
   rvcb_host i_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr),
                     .o_wdata(i_wdata));
   ////////////////////////////////////////////////////////////////////////////
   // Writable bits per address; the hole keeps nothing
   function [7:0] msk(input [7:0] x);
      case (x)
         8'h2E, 8'h32: msk = 8'h5F;
         8'h36, 8'h37: msk = 8'h47;
         8'h2F, 8'h30, 8'h31, 8'h33, 8'h34, 8'h35: msk = 8'h3F;
         8'h38, 8'h39, 8'h3F, 8'h40: msk = 8'h0F;
         8'h3A: msk = 8'h00;
         default: msk = 8'h1F;
      endcase
   endfunction
   // Reset word: boot code for active registers, fixed otherwise
   function [7:0] rstv(input [7:0] x);
      case (x)
         8'h2E, 8'h32, 8'h36: rstv = 8'h01;
         8'h2F, 8'h33, 8'h38, 8'h3B, 8'h3D, 8'h3F, 8'h41, 8'h43: rstv = boot & msk(x);
         default: rstv = 8'h00;
      endcase
   endfunction
   task chk(input [7:0] s, input [7:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, s, e);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock and a hang limit well past the expected run
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end
   // Reset map, readback masks, then code selection across sleep and scaling
   initial begin
      i_rst = 1'b1;
      i_sleep_allow = 1'b0;
      {i_scaling_pin1, i_scaling_pin2} = 2'b00;
      {i_scaling_pin1_polarity, i_scaling_pin2_polarity} = 2'b11;
      boot = 8'hE5;
      w(12);
      i_rst = 1'b0;
      for (a = 8'h2E; a <= 8'h44; a++) begin
         i_host.rd(a, v);
         chk(v, rstv(a));
      end
      foreach (pat[i]) for (a = 8'h2E; a <= 8'h44; a++) begin
         i_host.wr(a, pat[i]);
         i_host.rd(a, v);
         chk(v, msk(a) & pat[i]);
      end
      foreach (setup[i]) i_host.wr(setup[i][15:8], setup[i][7:0]);
      w(2);
      chk({o_conv1_phase_invert, o_conv1_scaling_slew, o_conv1_min_coil_current}, 8'h3A);
      chk({o_conv2_phase_invert, o_conv2_scaling_slew, o_conv2_min_coil_current}, 8'h10);
      chk({o_conv3_phase_invert, o_conv3_min_coil_current}, 8'h00);
      chk({o_conv4_phase_invert, o_conv4_min_coil_current}, 8'h0E);
      chk(o_conv1_code, 8'h11);
      chk(o_conv2_code, 8'h10);
      chk({o_conv4_code, o_linreg3_code}, 8'h53);
      chk({o_linreg1_code, o_linreg2_code[2:0]}, 8'h80);
      chk({o_linreg4_code, o_linreg5_code[2:0]}, 8'h80);
      i_sleep_allow = 1'b1;
      w(2);
      chk({o_sleep_state, o_conv1_code}, 8'h62);
      chk({o_conv4_code, o_linreg3_code}, 8'h9C);
      i_scaling_pin1 = 1'b1;
      w(1);
      chk({o_conv1_code, o_conv2_code[1:0]}, 8'hCC);
      i_scaling_pin1_polarity = 1'b0;
      w(1);
      chk(o_conv1_code, 8'h22);
      i_scaling_pin1 = 1'b0;
      i_scaling_pin2 = 1'b1;
      w(1);
      chk({o_conv1_code, o_conv2_code[1:0]}, 8'hCE);
      i_sleep_allow = 1'b0;
      w(1);
      chk({o_sleep_state, o_wake_pulse}, 8'h01);
      w(1);
      chk({o_wake_pulse, o_conv4_code}, 8'h05);
      test_done;
   end
endmodule // test_regulator_voltage_config_bank
bind rvcb_regbank rvcb_checker i_chk (.*);
